// ---- inc/udc_cfg.svh ----
`ifndef UDC_CFG_SVH
`define UDC_CFG_SVH
`define UDC_WIDTH      4
`define UDC_ZERO       4'h0
`define UDC_TOP        4'hf
`define UDC_RST_COUNT  4'h0
`endif

// ---- inc/udc_pkg.sv ----
`default_nettype none
package udc_pkg;
  typedef logic [3:0] udc_count_t;
  typedef enum logic [1:0] {
    UDC_HOLD,
    UDC_UP,
    UDC_DOWN
  } udc_step_e;
endpackage : udc_pkg
`default_nettype wire

// ---- hdl/udc_edge.sv ----
`include "udc_cfg.svh"
`default_nettype none
// Rising-edge detector for a count input sampled on the system clock.
module udc_edge (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic level_in,
  output logic      rise
);
  logic prev;

  // Starting high means an input held high through reset is not a rising edge.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev <= 1'b1;
    end else begin
      prev <= level_in;
    end
  end

  assign rise = level_in & ~prev;
endmodule : udc_edge
`default_nettype wire

// ---- hdl/udc_step.sv ----
`include "udc_cfg.svh"
`default_nettype none
// Next-count arithmetic with priority clear, load, then count.
module udc_step (
  input  wire logic                    zero_in,
  input  wire logic                    load_n,
  input  wire logic [`UDC_WIDTH-1:0]   preset,
  input  wire udc_pkg::udc_step_e      step,
  input  wire logic [`UDC_WIDTH-1:0]   count,
  output logic      [`UDC_WIDTH-1:0]   next_count
);
  function automatic logic [`UDC_WIDTH-1:0] wrap_add(
    input logic [`UDC_WIDTH-1:0] a,
    input logic [`UDC_WIDTH-1:0] d
  );
    wrap_add = a + d;
  endfunction : wrap_add

  wire logic [`UDC_WIDTH-1:0] inc_val = wrap_add(count, 4'h1);
  wire logic [`UDC_WIDTH-1:0] dec_val = wrap_add(count, 4'hf);
  wire logic [`UDC_WIDTH-1:0] cnt_val =
    (step == udc_pkg::UDC_UP)   ? inc_val :
    (step == udc_pkg::UDC_DOWN) ? dec_val : count;

  assign next_count = zero_in ? `UDC_ZERO :
                      !load_n ? preset : cnt_val;
endmodule : udc_step
`default_nettype wire

// ---- hdl/udc_counter.sv ----
// Notes on behaviour
// - All four count bits update together in one register.
// - Counting happens only on rising edges of the up or down input.
// - Up edge increments, down edge decrements; idle input is held high.
// - Load low copies preset inputs into the count regardless of counting.
// - Clear high forces the count to zero without a count edge.
// - Clear outranks load and both count inputs.
// - Underflow output low only at count zero with down input low at the previous clock.
// - Overflow output low only at count fifteen with up input low at the previous clock.
// - Counting up from fifteen wraps to zero.
// - Counting down from zero wraps to fifteen.
`include "udc_cfg.svh"
`default_nettype none
module udc_counter (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  count_up,
  input  wire logic                  count_down,
  input  wire logic                  load_n,
  input  wire logic                  async_zero_input,
  input  wire logic [`UDC_WIDTH-1:0] preset,
  output logic      [`UDC_WIDTH-1:0] count,
  output logic                       underflow_pulse_n,
  output logic                       overflow_pulse_n
);
  wire logic up_rise;
  wire logic down_rise;
  wire logic [`UDC_WIDTH-1:0] next_count;
  wire udc_pkg::udc_step_e step;

  udc_edge u_up_edge (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .level_in (count_up),
    .rise     (up_rise)
  );

  udc_edge u_down_edge (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .level_in (count_down),
    .rise     (down_rise)
  );

  // An edge on one input counts only while the other stays high; both edges
  // at once is a driver error and is ignored rather than guessed at.
  wire logic up_only   = up_rise && count_down && !down_rise;
  wire logic down_only = down_rise && count_up && !up_rise;

  assign step = up_only   ? udc_pkg::UDC_UP :
                down_only ? udc_pkg::UDC_DOWN :
                udc_pkg::UDC_HOLD;

  udc_step u_step (
    .zero_in    (async_zero_input),
    .load_n     (load_n),
    .preset     (preset),
    .step       (step),
    .count      (count),
    .next_count (next_count)
  );

  // The count sits in one vector register so no ripple states are seen.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= `UDC_RST_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // Flags are computed from the next state so they stay registered yet
  // line up with the count shown in the same cycle.
  wire logic next_under_n = !((next_count == `UDC_ZERO) && !count_down);
  wire logic next_over_n  = !((next_count == `UDC_TOP) && !count_up);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      underflow_pulse_n <= 1'b1;
      overflow_pulse_n  <= 1'b1;
    end else begin
      underflow_pulse_n <= next_under_n;
      overflow_pulse_n  <= next_over_n;
    end
  end

  AST_CLEAR_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    async_zero_input |=> (count == `UDC_ZERO))
    else $error("count not zero after clear");

  AST_CLEAR_PRIO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (async_zero_input && !load_n) |=> (count == `UDC_ZERO))
    else $error("load overrode clear");

  AST_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!async_zero_input && !load_n) |=> (count == $past(preset)))
    else $error("load did not copy preset");

  AST_UP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!async_zero_input && load_n && count_up && !$past(count_up) && count_down
     && $past(count_down) && !$past(sys_rst))
    |=> (count == 4'(($past(count) + 4'h1))))
    else $error("up edge did not increment");

  AST_DOWN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!async_zero_input && load_n && count_down && !$past(count_down) && count_up
     && $past(count_up) && !$past(sys_rst))
    |=> (count == 4'(($past(count) - 4'h1))))
    else $error("down edge did not decrement");

  AST_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!async_zero_input && load_n && $stable(count_up) && $stable(count_down))
    |=> $stable(count))
    else $error("count moved without edge");

  AST_UNDER: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst && $past(!sys_rst) |->
    (underflow_pulse_n == !((count == `UDC_ZERO) && !$past(count_down))))
    else $error("underflow flag wrong");

  AST_OVER: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sys_rst && $past(!sys_rst) |->
    (overflow_pulse_n == !((count == `UDC_TOP) && !$past(count_up))))
    else $error("overflow flag wrong");

  COV_WRAP_UP: cover property (@(posedge clk_sys) disable iff (sys_rst)
    (count == `UDC_TOP) ##1 (count == `UDC_ZERO));
  COV_WRAP_DOWN: cover property (@(posedge clk_sys) disable iff (sys_rst)
    (count == `UDC_ZERO) ##1 (count == `UDC_TOP));
  COV_LOAD_RESUME: cover property (@(posedge clk_sys) disable iff (sys_rst)
    !load_n ##1 load_n ##[1:8] (step != udc_pkg::UDC_HOLD));
  COV_BORROW: cover property (@(posedge clk_sys) disable iff (sys_rst)
    !underflow_pulse_n);
endmodule : udc_counter
`default_nettype wire

// ---- tb/udc_far_logic.sv ----
`default_nettype none
// Surrounding logic that pulses one count input low while the other rests high.
module udc_far_logic (
  input  wire logic [1:0] op,
  output logic            count_up,
  output logic            count_down
);
  // Only one input ever goes low at a time, but a pulse that ends as the other input goes low is refused.
  assign count_up   = (op != 2'h1);
  assign count_down = (op != 2'h2);
endmodule : udc_far_logic
`default_nettype wire

// ---- tb/test_udc_counter.sv ----
`include "udc_cfg.svh"
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_udc_counter;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0, sys_rst = 1'b1, load_n = 1'b1, async_zero_input = 1'b0;
  logic [1:0] op = 2'h0;
  logic [3:0] preset = 4'h0, exp_cnt = 4'h0, count;
  logic       count_up, count_down, underflow_pulse_n, overflow_pulse_n;
  logic       su = 1'b1, sd = 1'b1;
  logic [31:0] r;
  int         error_cnt = 0, n_tests = 0, cyc = 0;
  integer     seed = 32'h572dc296;
  initial forever #25 clk_sys = ~clk_sys;
  udc_far_logic u_udc_far_logic (.op(op), .count_up(count_up), .count_down(count_down));
  udc_counter u_udc_counter (.clk_sys(clk_sys), .sys_rst(sys_rst), .count_up(count_up),
    .count_down(count_down), .load_n(load_n), .async_zero_input(async_zero_input),
    .preset(preset), .count(count), .underflow_pulse_n(underflow_pulse_n),
    .overflow_pulse_n(overflow_pulse_n));
  function automatic logic [3:0] nxt(input logic [3:0] c);
    if (sys_rst || async_zero_input) return 4'h0;
    if (!load_n) return preset;
    if (count_up && !su && count_down && sd) return c + 4'h1;
    if (count_down && !sd && count_up && su) return c - 4'h1;
    return c;
  endfunction : nxt
  task give_verdict;
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task step(input logic [1:0] o, input logic l, input logic c, input logic [3:0] p);
    op <= o;
    load_n <= l;
    async_zero_input <= c;
    preset <= p;
    @(posedge clk_sys);
  endtask : step
  // The history of each count input restarts high, as the design's does.
  always @(posedge clk_sys) begin
    exp_cnt <= nxt(exp_cnt);
    su <= sys_rst | count_up;
    sd <= sys_rst | count_down;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  always @(negedge clk_sys) begin
    if (!sys_rst) begin
      `CHK(count, exp_cnt)
      `CHK(overflow_pulse_n, !(exp_cnt == 4'hf && !su))
      `CHK(underflow_pulse_n, !(exp_cnt == 4'h0 && !sd))
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    step(2'h0, 1'b1, 1'b1, 4'h0);
    step(2'h0, 1'b0, 1'b1, 4'h7);
    step(2'h0, 1'b0, 1'b0, 4'hd);
    for (int i = 0; i < 10; i++) begin
      step((i < 5) ? 2'h1 : 2'h2, 1'b1, 1'b0, 4'h0);
      step(2'h0, 1'b1, 1'b0, 4'h0);
    end
    step(2'h1, 1'b0, 1'b0, 4'h5);
    step(2'h0, 1'b1, 1'b0, 4'h0);
    for (int i = 0; i < 2000; i++) begin
      r = $random(seed);
      step(r[1:0], r[7:3] != 5'h0, r[12:8] == 5'h0, r[16:13]);
    end
    give_verdict();
  end
endmodule : test_udc_counter
`default_nettype wire
